// ==== dv/motion_data_readback_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module motion_data_readback_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic port_select_n,
    input wire logic [7:0] host_data,
    input wire logic host_data_oe,
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe,
    input wire logic host_irq,
    input wire logic [7:0] bus
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // bus ownership and strobe shape
    AST_ONE_DRIVER: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the data bus");
    AST_RD_WR_EXCL: assert property (!(!rd_n && !wr_n))
        else $error("read and write strobes low together");
    AST_RD_WIDTH: assert property ($fell(rd_n) |-> (!rd_n) [*6] ##1 rd_n)
        else $error("read strobe width wrong");
    AST_WR_WIDTH: assert property ($fell(wr_n) |-> (!wr_n) [*6] ##1 wr_n)
        else $error("write strobe width wrong");
    // select decode and port select held per access
    AST_STROBE_SELECTED: assert property ((!rd_n || !wr_n) |-> !cs_n)
        else $error("strobe without chip select");
    AST_PORT_HELD: assert property (!cs_n && $past(!cs_n) |-> $stable(port_select_n))
        else $error("port select moved inside an access");
    // device answers only inside a read, host write data held under strobe
    AST_OE_IN_READ: assert property ($rose(dev_data_oe) |-> !rd_n && !cs_n)
        else $error("device drove bus outside a read");
    AST_OE_RELEASE: assert property ($rose(rd_n) |-> ##[1:4] !dev_data_oe)
        else $error("device kept bus after read");
    AST_WDATA_HELD: assert property (!wr_n && $past(!wr_n) |-> $stable(host_data) && host_data_oe)
        else $error("write data moved under strobe");
    // main traffic seen
    cover property ($rose(dev_data_oe) && port_select_n && bus == dev_data);
    cover property ($rose(host_irq));
    cover property ($fell(wr_n) && port_select_n);
endmodule
`default_nettype wire

// ==== dv/motion_data_readback_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module motion_data_readback_tb;
    import motion_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid, req_ready, req_wr_byte, rsp_valid, irq_out;
    logic [7:0] req_cmd, req_wdata, last_status;
    logic [2:0] req_rd_bytes;
    logic [31:0] rsp_data, setpoint_pos, setpoint_vel, feedback_pos, pos_exp;
    logic [15:0] integ_sum, measured_vel;
    logic motor_off, evt_breakpoint, evt_pos_error, evt_wrap, evt_traj_done;
    logic enc_phase_a, enc_phase_b, enc_index_n;
    logic [1:0] quad [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    logic [31:0] exp_q [$];
    int step_idx = 0;
    int wait_n = 0;
    int miscompares = 0;
    int samples_checked = 0;

    always #25 core_clk = ~core_clk;

    motion_host_if u_motion_host_if ();
    motion_readback_dev u_motion_readback_dev (.core_clk(core_clk), .rst_n(rst_n),
        .host_bus(u_motion_host_if), .setpoint_pos(setpoint_pos), .setpoint_vel(setpoint_vel),
        .integ_sum(integ_sum), .motor_off(motor_off), .evt_breakpoint(evt_breakpoint),
        .evt_pos_error(evt_pos_error), .evt_wrap(evt_wrap), .evt_traj_done(evt_traj_done),
        .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b), .enc_index_n(enc_index_n),
        .feedback_pos(feedback_pos), .measured_vel(measured_vel));
    motion_readback_host u_motion_readback_host (.core_clk(core_clk), .rst_n(rst_n),
        .dev_bus(u_motion_host_if), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_rd_bytes(req_rd_bytes), .req_wr_byte(req_wr_byte),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .last_status(last_status), .irq_out(irq_out));
    motion_data_readback_monitor u_motion_data_readback_monitor (.core_clk(core_clk),
        .rst_n(rst_n), .cs_n(u_motion_host_if.cs_n), .rd_n(u_motion_host_if.rd_n),
        .wr_n(u_motion_host_if.wr_n), .port_select_n(u_motion_host_if.port_select_n),
        .host_data(u_motion_host_if.host_data), .host_data_oe(u_motion_host_if.host_data_oe),
        .dev_data(u_motion_host_if.dev_data), .dev_data_oe(u_motion_host_if.dev_data_oe),
        .host_irq(u_motion_host_if.host_irq), .bus(u_motion_host_if.bus));

    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one host request, expected readback queued
    task automatic do_req(input logic [7:0] cmd, input logic [2:0] nb, input logic wr,
        input logic [7:0] wd, input logic [31:0] exp);
        int n;
        n = 0;
        @(negedge core_clk);
        req_cmd = cmd;
        req_rd_bytes = nb;
        req_wr_byte = wr;
        req_wdata = wd;
        req_valid = 1'b1;
        exp_q.push_back(exp);
        @(negedge core_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 3000)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // one quadrature step, dir +1 forward, -1 reverse
    task automatic enc_step(input int dir);
        step_idx = (step_idx + dir) & 3;
        @(negedge core_clk);
        {enc_phase_a, enc_phase_b} = quad[step_idx];
        pos_exp = pos_exp + 32'(dir);
        repeat (4) @(negedge core_clk);
    endtask

    // response watcher, away from the edge that launches the pulse
    always @(negedge core_clk)
    begin
        if (rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected rsp", 32'h1, 32'h0);
            else
                check("rsp_data", rsp_data, exp_q.pop_front());
        end
    end

    // watchdog
    initial
    begin
        #(50 * 40000);
        miscompares++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        req_valid = 1'b0;
        req_cmd = 8'h00;
        req_rd_bytes = 3'h0;
        req_wr_byte = 1'b0;
        req_wdata = 8'h00;
        {motor_off, evt_breakpoint, evt_pos_error, evt_wrap, evt_traj_done} = 5'h00;
        {enc_phase_a, enc_phase_b} = 2'b00;
        enc_index_n = 1'b1;
        pos_exp = 32'h0;
        void'($urandom(32'h2d38));
        setpoint_pos = $urandom();
        setpoint_vel = 32'hFFFF_0000 | $urandom();
        integ_sum = 16'($urandom());
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        // readbacks, long then short, with an abandoned command between
        do_req(CMD_RD_SETPOINT_POS, BYTES_LONG, 1'b0, 8'h00, setpoint_pos);
        do_req(CMD_RD_SETPOINT_VEL, BYTES_LONG, 1'b0, 8'h00, setpoint_vel);
        do_req(CMD_RD_SETPOINT_POS, 3'h0, 1'b0, 8'h00, 32'h0);
        do_req(CMD_RD_INTEG_SUM, BYTES_SHORT, 1'b0, 8'h00, {16'h0, integ_sum});
        // encoder: forward, one-cycle glitch, reverse past zero
        repeat (6) enc_step(1);
        @(negedge core_clk);
        enc_phase_b = ~enc_phase_b;
        @(negedge core_clk);
        enc_phase_b = ~enc_phase_b;
        repeat (4) @(negedge core_clk);
        repeat (9) enc_step(-1);
        check("feedback_pos", feedback_pos, pos_exp);
        do_req(CMD_RD_FEEDBACK_POS, BYTES_LONG, 1'b0, 8'h00, pos_exp);
        // index capture
        do_req(CMD_ARM_INDEX_CAPTURE, 3'h0, 1'b0, 8'h00, 32'h0);
        enc_step(1);
        enc_index_n = 1'b0;
        repeat (4) @(negedge core_clk);
        enc_index_n = 1'b1;
        do_req(CMD_RD_INDEX_CAPTURE, BYTES_LONG, 1'b0, 8'h00, pos_exp);
        // each event raises the pin when unmasked
        do_req(CMD_CLEAR_FLAGS, 3'h0, 1'b0, 8'h00, 32'h0);
        do_req(CMD_LOAD_IRQ_MASK, 3'h0, 1'b1, 8'h7E, 32'h0);
        for (int e = 0; e < 4; e++)
        begin
            @(negedge core_clk);
            {evt_breakpoint, evt_pos_error, evt_wrap, evt_traj_done} = 4'h8 >> e;
            @(negedge core_clk);
            {evt_breakpoint, evt_pos_error, evt_wrap, evt_traj_done} = 4'h0;
            repeat (4) @(negedge core_clk);
            check("irq_out set", irq_out, 32'h1);
            do_req(CMD_CLEAR_FLAGS, 3'h0, 1'b0, 8'h00, 32'h0);
            repeat (4) @(negedge core_clk);
            check("irq_out clear", irq_out, 32'h0);
        end
        // masked: pin quiet, status still shows flags
        do_req(CMD_LOAD_IRQ_MASK, 3'h0, 1'b1, 8'h00, 32'h0);
        @(negedge core_clk);
        evt_wrap = 1'b1;
        motor_off = 1'b1;
        @(negedge core_clk);
        evt_wrap = 1'b0;
        repeat (4) @(negedge core_clk);
        check("irq_out masked", irq_out, 32'h0);
        do_req(CMD_RD_INTEG_SUM, BYTES_SHORT, 1'b0, 8'h00, {16'h0, integ_sum});
        check("status wrap", last_status[ST_WRAP], 32'h1);
        check("status motor off", last_status[ST_MOTOR_OFF], 32'h1);
        check("status busy", last_status[ST_BUSY], 32'h0);
        // data reads with no read sequence open flag a command error
        do_req(CMD_CLEAR_FLAGS, BYTES_SHORT, 1'b0, 8'h00, 32'h0);
        check("status cmd err", last_status[ST_CMD_ERR], 32'h1);
        // measured velocity: quiet periods give zero, then signed counts per period
        repeat (2 * SAMPLE_CYCLES + 16) @(negedge core_clk);
        check("vel idle", measured_vel, 32'h0);
        enc_step(1);
        wait_n = 0;
        while (measured_vel === 16'h0000 && wait_n < 2 * SAMPLE_CYCLES + 16)
        begin
            @(negedge core_clk);
            wait_n++;
        end
        check("vel forward", measured_vel, 32'h1);
        repeat (3) enc_step(-1);
        wait_n = 0;
        while (measured_vel === 16'h0001 && wait_n < 2 * SAMPLE_CYCLES + 16)
        begin
            @(negedge core_clk);
            wait_n++;
        end
        check("vel reverse", measured_vel, 32'h0000_FFFD);
        do_req(CMD_RD_MEASURED_VEL, BYTES_SHORT, 1'b0, 8'h00, 32'h0000_FFFD);
        repeat (4) @(negedge core_clk);
        check("pending rsp", exp_q.size(), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== src/motion_host_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface motion_host_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic port_select_n;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] dev_data;
    logic dev_data_oe;
    logic host_irq;
    logic [7:0] bus;
    // resolved data wire, idle high
    assign bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);
    modport device (
        input cs_n, rd_n, wr_n, port_select_n, bus,
        output dev_data, dev_data_oe, host_irq
    );
    modport host (
        input bus, host_irq,
        output cs_n, rd_n, wr_n, port_select_n, host_data, host_data_oe
    );
endinterface
`default_nettype wire

// ==== src/motion_pkg.sv ====
package motion_pkg;
    // widths
    localparam int POS_W = 32;
    localparam int SUM_W = 16;
    // command codes
    localparam logic [7:0] CMD_RD_SETPOINT_VEL = 8'h07;
    localparam logic [7:0] CMD_RD_SETPOINT_POS = 8'h08;
    localparam logic [7:0] CMD_RD_INDEX_CAPTURE = 8'h09;
    localparam logic [7:0] CMD_RD_FEEDBACK_POS = 8'h0A;
    localparam logic [7:0] CMD_RD_MEASURED_VEL = 8'h0B;
    localparam logic [7:0] CMD_RD_INTEG_SUM = 8'h0D;
    localparam logic [7:0] CMD_LOAD_IRQ_MASK = 8'h1C;
    localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1D;
    localparam logic [7:0] CMD_ARM_INDEX_CAPTURE = 8'h20;
    // byte counts of readback commands
    localparam logic [2:0] BYTES_LONG = 3'h4;
    localparam logic [2:0] BYTES_SHORT = 3'h2;
    // status byte bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_CMD_ERR = 1;
    localparam int ST_TRAJ_DONE = 2;
    localparam int ST_INDEX = 3;
    localparam int ST_WRAP = 4;
    localparam int ST_POS_ERR = 5;
    localparam int ST_BREAK = 6;
    localparam int ST_MOTOR_OFF = 7;
    // reset values
    localparam logic [6:1] FLAGS_RST = 6'h00;
    localparam logic [6:1] MASK_RST = 6'h00;
    localparam logic [31:0] POS_RST = 32'h0000_0000;
    // timing counts in core_clk cycles
    localparam logic [3:0] BUSY_CYCLES = 4'h4;
    localparam logic [15:0] SAMPLE_CYCLES = 16'h07D0;
    localparam logic [3:0] STROBE_CYCLES = 4'h6;
    localparam logic [3:0] ACC_LAST = 4'(2 * STROBE_CYCLES - 1);
    // measured velocity limits
    localparam logic [31:0] VEL_MAX = 32'h0000_3FFF;
    localparam logic [31:0] VEL_MIN = 32'hFFFF_C000;
    // host address map
    localparam logic [7:0] DEV_BASE_ADDR = 8'h40;
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_READ = 2'b01,
        DS_WRITE = 2'b10
    } dev_state_t;
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_POLL = 3'b001,
        HS_CMD = 3'b010,
        HS_WDATA = 3'b011,
        HS_RDATA = 3'b100,
        HS_DONE = 3'b101
    } host_state_t;
endpackage

// ==== src/motion_readback_dev.sv ====
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - command 08 returns four-byte setpoint position
// - setpoint position sent most significant byte first
// - command 0A returns four-byte feedback position
// - command 07: integer velocity high, fraction low
// - setpoint velocity is signed two's complement
// - command 0B returns two-byte signed integer velocity
// - measured velocity aligns after sixteen-bit left shift
// - command 0D returns two-byte integrator sum
// - six conditions on interrupt pin and status
// - status shows flags regardless of mask
// - new command abandons unfinished byte sequence
// - host masks its interrupt during sequences
// - eight-bit bus with select and strobes
// - host decodes select, address bit drives port
// - encoder phases plus optional index input
// - unused index input held high
// - transient phase noise counts no net step
// - no glitch filter on encoder inputs
// - accesses while busy ignored, no error
module motion_readback_dev (
    input wire logic core_clk,
    input wire logic rst_n,
    motion_host_if.device host_bus,
    input wire logic [motion_pkg::POS_W-1:0] setpoint_pos,
    input wire logic [motion_pkg::POS_W-1:0] setpoint_vel,
    input wire logic [motion_pkg::SUM_W-1:0] integ_sum,
    input wire logic motor_off,
    input wire logic evt_breakpoint,
    input wire logic evt_pos_error,
    input wire logic evt_wrap,
    input wire logic evt_traj_done,
    input wire logic enc_phase_a,
    input wire logic enc_phase_b,
    input wire logic enc_index_n,
    output logic [motion_pkg::POS_W-1:0] feedback_pos,
    output logic [15:0] measured_vel
);
    import motion_pkg::*;

    // pin vector: cs_n, rd_n, wr_n, port_select_n, data[7:0], a, b, index_n
    typedef struct packed {
        logic [14:0] s1;
        logic [14:0] s2;
        logic rd_n_p;
        logic wr_n_p;
        logic [1:0] ab_p;
        logic idx_n_p;
        dev_state_t st;
        logic [2:0] left;
        logic [31:0] word;
        logic [3:0] busy;
        logic [6:1] flags;
        logic [6:1] mask;
        logic armed;
        logic [31:0] pos;
        logic [31:0] idx_pos;
        logic [15:0] smp;
        logic [31:0] last_pos;
        logic [15:0] vel;
        logic [7:0] dout;
    } dev_regs_t;

    localparam dev_regs_t DEV_RST = '{
        s1: 15'h7FFF, s2: 15'h7FFF, rd_n_p: 1'b1, wr_n_p: 1'b1, ab_p: 2'h0,
        idx_n_p: 1'b1, st: DS_IDLE, left: 3'h0, word: 32'h0000_0000,
        busy: 4'h0, flags: FLAGS_RST, mask: MASK_RST, armed: 1'b0,
        pos: POS_RST, idx_pos: POS_RST, smp: 16'h0000, last_pos: POS_RST,
        vel: 16'h0000, dout: 8'h00
    };

    // quadrature step: 2'b01 forward, 2'b11 reverse, 2'b00 none
    function automatic logic [1:0] qd_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [1:0] chg;
        chg = prev ^ cur;
        if (chg == 2'h1 || chg == 2'h2)
            qd_step = (cur[1] ^ prev[0]) ? 2'h1 : 2'h3;
        else
            qd_step = 2'h0;
    endfunction

    // limit a count difference to the reportable velocity range
    function automatic logic [15:0] vel_clamp(input logic [31:0] diff);
        if ($signed(diff) > $signed(VEL_MAX))
            vel_clamp = VEL_MAX[15:0];
        else if ($signed(diff) < $signed(VEL_MIN))
            vel_clamp = VEL_MIN[15:0];
        else
            vel_clamp = diff[15:0];
    endfunction

    dev_regs_t q;
    dev_regs_t n;
    logic cs;
    logic rd_end;
    logic wr_end;
    logic busy;
    logic [7:0] din;
    logic [6:1] set;
    logic [6:1] clr;
    logic [1:0] step;
    logic [7:0] status;
    logic [7:0] data_byte;

    always_comb
    begin
        n = q;
        set = 6'h00;
        clr = 6'h00;
        // two-stage synchronisers on every pin, no filtering
        n.s1 = {host_bus.cs_n, host_bus.rd_n, host_bus.wr_n, host_bus.port_select_n,
                host_bus.bus, enc_phase_a, enc_phase_b, enc_index_n};
        n.s2 = q.s1;
        n.rd_n_p = q.s2[13];
        n.wr_n_p = q.s2[12];
        cs = !q.s2[14];
        din = q.s2[10:3];
        rd_end = cs && q.s2[13] && !q.rd_n_p;
        wr_end = cs && q.s2[12] && !q.wr_n_p;
        busy = (q.busy != 4'h0);
        if (busy)
            n.busy = q.busy - 4'h1;
        // host writes: commands on port select low, data otherwise
        if (wr_end && !busy)
        begin
            n.busy = BUSY_CYCLES;
            if (!q.s2[11])
            begin
                n.st = DS_IDLE;
                n.left = 3'h0;
                case (din)
                    CMD_RD_SETPOINT_POS:
                    begin
                        n.word = setpoint_pos;
                        n.left = BYTES_LONG;
                        n.st = DS_READ;
                    end
                    CMD_RD_FEEDBACK_POS:
                    begin
                        n.word = q.pos;
                        n.left = BYTES_LONG;
                        n.st = DS_READ;
                    end
                    CMD_RD_SETPOINT_VEL:
                    begin
                        n.word = setpoint_vel;
                        n.left = BYTES_LONG;
                        n.st = DS_READ;
                    end
                    CMD_RD_MEASURED_VEL:
                    begin
                        n.word = {16'h0000, q.vel};
                        n.left = BYTES_SHORT;
                        n.st = DS_READ;
                    end
                    CMD_RD_INTEG_SUM:
                    begin
                        n.word = {16'h0000, integ_sum};
                        n.left = BYTES_SHORT;
                        n.st = DS_READ;
                    end
                    CMD_RD_INDEX_CAPTURE:
                    begin
                        n.word = q.idx_pos;
                        n.left = BYTES_LONG;
                        n.st = DS_READ;
                    end
                    CMD_ARM_INDEX_CAPTURE: n.armed = 1'b1;
                    CMD_LOAD_IRQ_MASK: n.st = DS_WRITE;
                    CMD_CLEAR_FLAGS: clr = 6'h3F;
                    default: ;
                endcase
            end
            else if (q.st == DS_WRITE)
            begin
                n.mask = din[6:1];
                n.st = DS_IDLE;
            end
            else
                set[ST_CMD_ERR] = 1'b1;
        end
        // host data reads step through the latched word
        if (rd_end && !busy && q.s2[11])
        begin
            n.busy = BUSY_CYCLES;
            if (q.st == DS_READ)
            begin
                n.left = q.left - 3'h1;
                if (q.left == 3'h1)
                    n.st = DS_IDLE;
            end
            else
                set[ST_CMD_ERR] = 1'b1;
        end
        // quadrature count; a glitch steps one way then back
        step = qd_step(q.ab_p, q.s2[2:1]);
        n.ab_p = q.s2[2:1];
        if (step == 2'h1)
            n.pos = q.pos + 32'h1;
        else if (step == 2'h3)
            n.pos = q.pos - 32'h1;
        // index capture on falling edge when armed
        n.idx_n_p = q.s2[0];
        if (q.armed && q.idx_n_p && !q.s2[0])
        begin
            n.idx_pos = q.pos;
            n.armed = 1'b0;
            set[ST_INDEX] = 1'b1;
        end
        // integer counts per sample period
        n.smp = q.smp + 16'h1;
        if (q.smp == SAMPLE_CYCLES - 16'h1)
        begin
            n.smp = 16'h0000;
            n.vel = vel_clamp(q.pos - q.last_pos);
            n.last_pos = q.pos;
        end
        // sticky flags, set beats clear
        set[ST_BREAK] = evt_breakpoint;
        set[ST_POS_ERR] = evt_pos_error;
        set[ST_WRAP] = evt_wrap;
        set[ST_TRAJ_DONE] = evt_traj_done;
        n.flags = (q.flags & ~clr) | set;
        // output byte: status always live, data held while busy
        status = {motor_off, q.flags, busy};
        data_byte = (q.st == DS_READ) ? q.word[8 * (q.left - 3'h1) +: 8] : 8'h00;
        if (!q.s2[11])
            n.dout = status;
        else if (!busy)
            n.dout = data_byte;
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= DEV_RST;
        else
            q <= n;
    end

    // pin drive and core outputs
    assign host_bus.dev_data = q.dout;
    assign host_bus.dev_data_oe = !q.s2[14] && !q.s2[13];
    assign host_bus.host_irq = |(q.flags & q.mask);
    assign feedback_pos = q.pos;
    assign measured_vel = q.vel;
endmodule
`default_nettype wire

// ==== src/motion_readback_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module motion_readback_host (
    input wire logic core_clk,
    input wire logic rst_n,
    motion_host_if.host dev_bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_cmd,
    input wire logic [2:0] req_rd_bytes,
    input wire logic req_wr_byte,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid,
    output logic [motion_pkg::POS_W-1:0] rsp_data,
    output logic [7:0] last_status,
    output logic irq_out
);
    import motion_pkg::*;

    typedef struct packed {
        host_state_t st;
        host_state_t ret;
        logic [3:0] acc;
        logic [7:0] cmd;
        logic [7:0] wdata;
        logic wr_pend;
        logic [2:0] left;
        logic [31:0] word;
        logic rsp_v;
        logic [7:0] status;
    } host_regs_t;

    localparam host_regs_t HOST_RST = '{
        st: HS_IDLE, ret: HS_IDLE, acc: 4'h0, cmd: 8'h00, wdata: 8'h00,
        wr_pend: 1'b0, left: 3'h0, word: 32'h0000_0000, rsp_v: 1'b0, status: 8'h00
    };

    host_regs_t q;
    host_regs_t n;
    logic active;
    logic is_rd;
    logic low;
    logic fin;
    logic smp;
    logic [7:0] addr;

    always_comb
    begin
        n = q;
        n.rsp_v = 1'b0;
        active = (q.st != HS_IDLE) && (q.st != HS_DONE);
        is_rd = (q.st == HS_POLL) || (q.st == HS_RDATA);
        low = active && (q.acc < STROBE_CYCLES);
        smp = active && (q.acc == STROBE_CYCLES - 4'h1);
        fin = active && (q.acc == ACC_LAST);
        // address bit 0 picks command/status port or data port
        addr = {DEV_BASE_ADDR[7:1], (q.st == HS_WDATA) || (q.st == HS_RDATA)};
        if (active)
            n.acc = fin ? 4'h0 : q.acc + 4'h1;
        case (q.st)
            HS_IDLE:
            begin
                if (req_valid)
                begin
                    n.cmd = req_cmd;
                    n.wdata = req_wdata;
                    n.wr_pend = req_wr_byte;
                    n.left = req_rd_bytes;
                    n.word = 32'h0000_0000;
                    n.ret = HS_CMD;
                    n.st = HS_POLL;
                end
            end
            HS_POLL:
            begin
                // wait for busy clear before any access
                if (smp)
                    n.status = dev_bus.bus;
                if (fin && !q.status[ST_BUSY])
                    n.st = q.ret;
            end
            HS_CMD:
            begin
                if (fin)
                begin
                    n.st = HS_POLL;
                    if (q.wr_pend)
                        n.ret = HS_WDATA;
                    else if (q.left != 3'h0)
                        n.ret = HS_RDATA;
                    else
                        n.st = HS_DONE;
                end
            end
            HS_WDATA:
            begin
                if (fin)
                begin
                    n.st = (q.left != 3'h0) ? HS_POLL : HS_DONE;
                    n.ret = HS_RDATA;
                end
            end
            HS_RDATA:
            begin
                // bytes arrive most significant first
                if (smp)
                    n.word = {q.word[23:0], dev_bus.bus};
                if (fin)
                begin
                    n.left = q.left - 3'h1;
                    n.st = (q.left == 3'h1) ? HS_DONE : HS_POLL;
                end
            end
            HS_DONE:
            begin
                n.rsp_v = 1'b1;
                n.st = HS_IDLE;
            end
            default: n.st = HS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= HOST_RST;
        else
            q <= n;
    end

    // bus pins from current access
    // select drops in the last cycle so port select only moves between accesses
    assign dev_bus.cs_n = !(active && !fin && addr[7:1] == DEV_BASE_ADDR[7:1]);
    assign dev_bus.port_select_n = addr[0];
    assign dev_bus.rd_n = !(low && is_rd);
    assign dev_bus.wr_n = !(low && !is_rd);
    assign dev_bus.host_data = (q.st == HS_WDATA) ? q.wdata : q.cmd;
    assign dev_bus.host_data_oe = active && !is_rd;
    // interrupt passed on only between sequences
    assign irq_out = dev_bus.host_irq && (q.st == HS_IDLE);
    assign req_ready = (q.st == HS_IDLE);
    assign rsp_valid = q.rsp_v;
    assign rsp_data = q.word;
    assign last_status = q.status;
endmodule
`default_nettype wire
